// ### rtl/ppd_pkg.sv
/*
 * shared constants and types for the port pin / debug pin block:
 * register offsets, field positions, reset values and state layouts.
 * assumes an 8-bit port and a 4-bit register address on a plain port.
 */
package ppd_pkg;

    localparam int unsigned PPD_ADDR_W = 4;
    localparam int unsigned PPD_DATA_W = 8;

    // register offsets
    localparam logic [3:0] PPD_OFF_DATA  = 4'h0;  // port_data_register
    localparam logic [3:0] PPD_OFF_DIR   = 4'h1;  // port_direction_select
    localparam logic [3:0] PPD_OFF_ODS   = 4'h2;  // open_drain_select
    localparam logic [3:0] PPD_OFF_FSEL  = 4'h3;  // pin_function_select
    localparam logic [3:0] PPD_OFF_EDGE  = 4'h4;  // edge detection enables
    localparam logic [3:0] PPD_OFF_DBG   = 4'h5;  // debug_mode_control
    localparam logic [3:0] PPD_OFF_STAT  = 4'h6;  // interrupt status, w1c
    localparam logic [3:0] PPD_OFF_MASK  = 4'h7;  // interrupt mask
    localparam logic [3:0] PPD_OFF_BITOP = 4'h8;  // single-bit operation

    // pin positions
    localparam int unsigned PPD_NMI_BIT  = 2;     // port0_bit2_pin
    localparam int unsigned PPD_INT2_BIT = 5;     // port0_bit5_pin

    // edge register fields
    localparam int unsigned PPD_EDG_NMI_RISE  = 0;
    localparam int unsigned PPD_EDG_NMI_FALL  = 1;
    localparam int unsigned PPD_EDG_INT2_RISE = 2;
    localparam int unsigned PPD_EDG_INT2_FALL = 3;

    // status / mask fields
    localparam int unsigned PPD_ST_NMI  = 0;
    localparam int unsigned PPD_ST_INT2 = 1;

    // debug control field
    localparam int unsigned PPD_DBG_EN_BIT = 0;   // debug_pin_enable_bit

    // bit operation word: index [2:0], operation [5:4]
    localparam int unsigned PPD_BOP_IDX_LSB = 0;
    localparam int unsigned PPD_BOP_OP_LSB  = 4;
    localparam logic [1:0]  PPD_BOP_SET     = 2'h1;
    localparam logic [1:0]  PPD_BOP_CLR     = 2'h2;
    localparam logic [1:0]  PPD_BOP_INV     = 2'h3;

    // reset values
    localparam logic [7:0] PPD_RST_DIR  = 8'hFF;  // all pins input
    localparam logic [7:0] PPD_RST_ZERO = 8'h00;
    localparam logic       PPD_RST_DBG  = 1'b1;   // debug pin after pin reset

    typedef struct packed {
        logic [7:0] stage1;
        logic [7:0] stage2;
    } ppd_sync_s;

endpackage : ppd_pkg

// ### rtl/ppd_port.sv
/*
 * 8-bit general-purpose port with alternate functions, edge detection
 * for the nmi and int2 pins, and the shared debug reset pin.
 * assumes a plain register port on CLK_IN and pins asynchronous to it.
 */
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - A port-to-function switch on a high pin with rising edge selected raises nmi.
// - A function-to-port switch on a high pin with falling edge selected raises nmi.
// - Function select 0 gives port mode and 1 gives alternate-function mode.
// - Open-drain select acts whenever a pin is driven: in port mode while the direction bit is output, in function mode while ALT_OE_IN is set.
// - With direction input, data reads return the pin and writes go to the latch.
// - A bit operation reads all 8 bits, modifies one, and writes all 8 back.
// - After pin reset the shared pin is debug reset; high enters debug mode.
// - Internal resets leave the debug function and its control register alone.
// - The pull-down is on after pin reset and off once the enable is cleared.
// - An alternate-function input sees the pin level ANDed with function select.
// - With direction output, data reads return the latch in either mode.
module ppd_port (
    input  wire logic                        CLK_IN,         // 50 MHz system clock
    input  wire logic                        SYS_RST_IN,     // external pin reset
    input  wire logic                        INT_RST_IN,     // watchdog/monitor/lvd
    input  wire logic [ppd_pkg::PPD_ADDR_W-1:0] ADDR_IN,     // register address
    input  wire logic [ppd_pkg::PPD_DATA_W-1:0] WDATA_IN,    // write data
    input  wire logic                        WR_IN,          // write strobe
    input  wire logic                        RD_IN,          // read strobe
    output logic      [ppd_pkg::PPD_DATA_W-1:0] RDATA_OUT,   // read data, next cycle
    input  wire logic [7:0]                  PIN_IN,         // pin levels
    output logic      [7:0]                  PIN_OUT,        // pin drive value
    output logic      [7:0]                  PIN_OE_OUT,     // pin drive enable
    input  wire logic [7:0]                  ALT_OUT_IN,     // peripheral outputs
    input  wire logic [7:0]                  ALT_OE_IN,      // peripheral enables
    output logic      [7:0]                  ALT_SIG_OUT,    // gated peripheral inputs
    output logic                             NMI_OUT,        // nmi request pulse
    output logic                             IRQ_OUT,        // masked interrupt level
    output logic                             PULLDOWN_OUT,   // debug pin pull-down
    output logic                             DEBUG_MODE_OUT  // debug pins enabled
);
    import ppd_pkg::*;

    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] dir;
        logic [7:0] ods;
        logic [7:0] fsel;
        logic [3:0] edges;
        logic       dbg_en;
        logic [1:0] status;
        logic [1:0] mask;
        logic       prev_nmi;
        logic       prev_int2;
        logic [7:0] rdata;
        logic [7:0] pin_out;
        logic [7:0] pin_oe;
        logic [7:0] alt_sig;
        logic       nmi;
        logic       irq;
        logic       dbg_mode;
    } ppd_state_s;

    localparam ppd_state_s PPD_RST_STATE = '{
        latch: PPD_RST_ZERO, dir: PPD_RST_DIR, ods: PPD_RST_ZERO,
        fsel: PPD_RST_ZERO, edges: 4'h0, dbg_en: PPD_RST_DBG,
        status: 2'h0, mask: 2'h0, prev_nmi: 1'b0, prev_int2: 1'b0,
        rdata: PPD_RST_ZERO, pin_out: PPD_RST_ZERO, pin_oe: PPD_RST_ZERO,
        alt_sig: PPD_RST_ZERO, nmi: 1'b0, irq: 1'b0, dbg_mode: 1'b0};

    ppd_state_s s_reg;
    ppd_state_s s_next;
    logic [7:0] pin_s;

    ////////////////////////////////////////////////////////////////////////////
    // functions

    // what software sees at the data register
    function automatic logic [7:0] port_view(input logic [7:0] latch,
                                             input logic [7:0] dir,
                                             input logic [7:0] pins);
        port_view = (dir & pins) | (~dir & latch);
    endfunction

    // one-bit set, clear or invert on a full byte
    function automatic logic [7:0] bit_apply(input logic [7:0] val,
                                             input logic [2:0] idx,
                                             input logic [1:0] op);
        logic [7:0] one;
        one = 8'h01 << idx;
        case (op)
            PPD_BOP_SET: bit_apply = val | one;
            PPD_BOP_CLR: bit_apply = val & ~one;
            PPD_BOP_INV: bit_apply = val ^ one;
            default:     bit_apply = val;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser

    ppd_sync u_sync (
        .clk_in   (CLK_IN),
        .rst_in   (SYS_RST_IN),
        .async_in (PIN_IN),
        .sync_out (pin_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        logic [7:0] view;
        logic [7:0] wr_clr;
        logic [1:0] ev;
        logic       g_nmi;
        logic       g_int2;
        logic       drv_val;
        logic       drv_en;
        view    = port_view(s_reg.latch, s_reg.dir, pin_s);
        wr_clr  = 8'h00;
        ev      = 2'h0;
        drv_val = 1'b0;
        drv_en  = 1'b0;
        g_nmi   = 1'b0;
        g_int2  = 1'b0;
        s_next  = s_reg;

        // register reads, answered one cycle later
        if (RD_IN) begin
            case (ADDR_IN)
                PPD_OFF_DATA: s_next.rdata = view;
                PPD_OFF_DIR:  s_next.rdata = s_reg.dir;
                PPD_OFF_ODS:  s_next.rdata = s_reg.ods;
                PPD_OFF_FSEL: s_next.rdata = s_reg.fsel;
                PPD_OFF_EDGE: s_next.rdata = {4'h0, s_reg.edges};
                PPD_OFF_DBG:  s_next.rdata = {7'h00, s_reg.dbg_en};
                PPD_OFF_STAT: s_next.rdata = {6'h00, s_reg.status};
                PPD_OFF_MASK: s_next.rdata = {6'h00, s_reg.mask};
                default:      s_next.rdata = 8'h00;
            endcase
        end

        // register writes
        if (WR_IN) begin
            case (ADDR_IN)
                PPD_OFF_DATA: s_next.latch = WDATA_IN;
                PPD_OFF_DIR:  s_next.dir = WDATA_IN;
                PPD_OFF_ODS:  s_next.ods = WDATA_IN;
                PPD_OFF_FSEL: s_next.fsel = WDATA_IN;
                PPD_OFF_EDGE: s_next.edges = WDATA_IN[3:0];
                PPD_OFF_DBG:  s_next.dbg_en = WDATA_IN[PPD_DBG_EN_BIT];
                PPD_OFF_STAT: wr_clr = WDATA_IN;
                PPD_OFF_MASK: s_next.mask = WDATA_IN[1:0];
                PPD_OFF_BITOP: s_next.latch = bit_apply(view,
                    WDATA_IN[PPD_BOP_IDX_LSB +: 3], WDATA_IN[PPD_BOP_OP_LSB +: 2]);
                default: ;
            endcase
        end

        s_next.alt_sig = pin_s & s_reg.fsel;
        g_nmi  = pin_s[PPD_NMI_BIT] & s_reg.fsel[PPD_NMI_BIT];
        g_int2 = pin_s[PPD_INT2_BIT] & s_reg.fsel[PPD_INT2_BIT] & ~s_reg.dbg_en;

        s_next.prev_nmi  = g_nmi;
        s_next.prev_int2 = g_int2;
        // mode switch seen as rising edge
        if (s_reg.edges[PPD_EDG_NMI_RISE] && g_nmi && !s_reg.prev_nmi) begin
            ev[PPD_ST_NMI] = 1'b1;
        end
        // mode switch seen as falling edge
        if (s_reg.edges[PPD_EDG_NMI_FALL] && !g_nmi && s_reg.prev_nmi) begin
            ev[PPD_ST_NMI] = 1'b1;
        end
        if ((s_reg.edges[PPD_EDG_INT2_RISE] && g_int2 && !s_reg.prev_int2) ||
            (s_reg.edges[PPD_EDG_INT2_FALL] && !g_int2 && s_reg.prev_int2)) begin
            ev[PPD_ST_INT2] = 1'b1;
        end
        s_next.nmi = ev[PPD_ST_NMI];

        // sticky status; a new event beats a same-cycle clear
        s_next.status = (s_reg.status & ~wr_clr[1:0]) | ev;
        s_next.irq    = |(s_next.status & s_next.mask);

        // pin drivers, one bit at a time
        for (int i = 0; i < 8; i++) begin
            drv_val = s_reg.fsel[i] ? ALT_OUT_IN[i] : s_reg.latch[i];
            drv_en  = s_reg.fsel[i] ? ALT_OE_IN[i] : ~s_reg.dir[i];
            if (drv_en && s_reg.ods[i]) begin
                s_next.pin_out[i] = 1'b0;
                s_next.pin_oe[i]  = ~drv_val;
            end else begin
                s_next.pin_out[i] = drv_val;
                s_next.pin_oe[i]  = drv_en;
            end
        end

        // shared pin listens as debug reset
        if (s_reg.dbg_en) begin
            s_next.pin_oe[PPD_INT2_BIT] = 1'b0;
        end
        s_next.dbg_mode = s_next.dbg_en & (s_reg.dbg_mode | pin_s[PPD_INT2_BIT]);

        if (INT_RST_IN) begin
            s_next          = PPD_RST_STATE;
            s_next.dbg_en   = s_reg.dbg_en;
            s_next.dbg_mode = s_reg.dbg_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; of the two resets only the pin reset restores the debug function

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            s_reg <= PPD_RST_STATE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign RDATA_OUT      = s_reg.rdata;
    assign PIN_OUT        = s_reg.pin_out;
    assign PIN_OE_OUT     = s_reg.pin_oe;
    assign ALT_SIG_OUT    = s_reg.alt_sig;
    assign NMI_OUT        = s_reg.nmi;
    assign IRQ_OUT        = s_reg.irq;
    assign PULLDOWN_OUT   = s_reg.dbg_en;
    assign DEBUG_MODE_OUT = s_reg.dbg_mode;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    property p_alt_gate;
        @(posedge CLK_IN) disable iff (SYS_RST_IN || INT_RST_IN)
        !INT_RST_IN |=> (ALT_SIG_OUT == ($past(pin_s) & $past(s_reg.fsel)));
    endproperty
    a_alt_gate: assert property (p_alt_gate)
        else $error("alternate input not gated by select");

    property p_nmi_rise;
        @(posedge CLK_IN) disable iff (SYS_RST_IN || INT_RST_IN)
        (!INT_RST_IN && s_reg.edges[PPD_EDG_NMI_RISE] && !s_reg.prev_nmi &&
         pin_s[PPD_NMI_BIT] && s_reg.fsel[PPD_NMI_BIT]) |=> (NMI_OUT && s_reg.status[0]);
    endproperty
    a_nmi_rise: assert property (p_nmi_rise)
        else $error("rising edge did not raise nmi");

    property p_nmi_fall;
        @(posedge CLK_IN) disable iff (SYS_RST_IN || INT_RST_IN)
        (!INT_RST_IN && s_reg.edges[PPD_EDG_NMI_FALL] && s_reg.prev_nmi &&
         !s_reg.fsel[PPD_NMI_BIT]) |=> NMI_OUT;
    endproperty
    a_nmi_fall: assert property (p_nmi_fall)
        else $error("switch to port did not raise nmi");

    property p_nmi_cause;
        @(posedge CLK_IN) disable iff (SYS_RST_IN || INT_RST_IN)
        NMI_OUT |-> ($past(s_reg.prev_nmi) != s_reg.prev_nmi);
    endproperty
    a_nmi_cause: assert property (p_nmi_cause)
        else $error("nmi without a change of gated input");

    property p_func_drive;
        @(posedge CLK_IN) disable iff (SYS_RST_IN || INT_RST_IN)
        (!INT_RST_IN && s_reg.fsel[0] && !s_reg.ods[0]) |=>
            (PIN_OE_OUT[0] == $past(ALT_OE_IN[0]));
    endproperty
    a_func_drive: assert property (p_func_drive)
        else $error("function mode not driven by peripheral");

    property p_od_input;
        @(posedge CLK_IN) disable iff (SYS_RST_IN || INT_RST_IN)
        (!s_reg.fsel[0] && s_reg.dir[0]) |=> !PIN_OE_OUT[0];
    endproperty
    a_od_input: assert property (p_od_input)
        else $error("input pin is driven");

    property p_read_data;
        @(posedge CLK_IN) disable iff (SYS_RST_IN || INT_RST_IN)
        (!INT_RST_IN && RD_IN && ADDR_IN == PPD_OFF_DATA) |=>
            (RDATA_OUT == (($past(s_reg.dir) & $past(pin_s)) |
                           (~$past(s_reg.dir) & $past(s_reg.latch))));
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("data read returns wrong source");

    property p_bitop;
        @(posedge CLK_IN) disable iff (SYS_RST_IN || INT_RST_IN)
        (!INT_RST_IN && WR_IN && ADDR_IN == PPD_OFF_BITOP && WDATA_IN[5:4] == PPD_BOP_SET) |=>
            (s_reg.latch == (($past(s_reg.dir) & $past(pin_s)) |
                             (~$past(s_reg.dir) & $past(s_reg.latch)) |
                             (8'h01 << $past(WDATA_IN[2:0]))));
    endproperty
    a_bitop: assert property (p_bitop)
        else $error("bit set did not land in latch");

    property p_int_rst;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        INT_RST_IN |=> (s_reg.dbg_en == $past(s_reg.dbg_en));
    endproperty
    a_int_rst: assert property (p_int_rst)
        else $error("internal reset changed debug control");

    property p_pulldown;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        (WR_IN && ADDR_IN == PPD_OFF_DBG && !WDATA_IN[0] && !INT_RST_IN) |=> !PULLDOWN_OUT;
    endproperty
    a_pulldown: assert property (p_pulldown)
        else $error("pull-down still on after clear");

    property p_debug_entry;
        @(posedge CLK_IN) disable iff (SYS_RST_IN || INT_RST_IN)
        (!INT_RST_IN && s_reg.dbg_en && pin_s[PPD_INT2_BIT] && !WR_IN) |=> DEBUG_MODE_OUT;
    endproperty
    a_debug_entry: assert property (p_debug_entry)
        else $error("high debug reset did not enter debug mode");

    // the debug reset pin is an input whenever the debug function owns it
    property p_debug_pin_quiet;
        @(posedge CLK_IN) disable iff (SYS_RST_IN || INT_RST_IN)
        s_reg.dbg_en |=> !PIN_OE_OUT[PPD_INT2_BIT];
    endproperty
    a_debug_pin_quiet: assert property (p_debug_pin_quiet)
        else $error("debug reset pin driven while debug function on");

    // a raised nmi status stays until software clears it
    property p_nmi_sticky;
        @(posedge CLK_IN) disable iff (SYS_RST_IN || INT_RST_IN)
        (!INT_RST_IN && s_reg.status[PPD_ST_NMI] &&
         !(WR_IN && ADDR_IN == PPD_OFF_STAT && WDATA_IN[PPD_ST_NMI]))
            |=> s_reg.status[PPD_ST_NMI];
    endproperty
    a_nmi_sticky: assert property (p_nmi_sticky)
        else $error("nmi status lost without a clear");

endmodule // ppd_port

// ### rtl/ppd_sync.sv
/*
 * two-flop synchroniser for the eight port pins.
 * assumes pins are asynchronous to CLK_IN; only stage2 leaves the module.
 */
`timescale 1ns/1ps

module ppd_sync (
    input  wire logic       clk_in,    // system clock
    input  wire logic       rst_in,    // async reset, active high
    input  wire logic [7:0] async_in,  // raw pin levels
    output logic      [7:0] sync_out   // synchronised levels
);
    import ppd_pkg::*;

    ppd_sync_s s_reg;
    ppd_sync_s s_next;

    // stage1 feeds stage2 and nothing else
    always_comb begin
        s_next.stage1 = async_in;
        s_next.stage2 = s_reg.stage1;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sync_out = s_reg.stage2;

endmodule // ppd_sync

// ### tb/ppd_pin_model.sv
/*
 * board model at the eight port pins: pull-up on the nmi pin,
 * switchable pull-down on the debug reset pin, bench-driven levels.
 * assumes the bench owns ext_val_in/ext_en_in and the device wins contention.
 */
`timescale 1ns/1ps

module ppd_pin_model (
    input  wire logic       clk_in,      // system clock
    input  wire logic [7:0] pin_out_in,  // device drive value
    input  wire logic [7:0] pin_oe_in,   // device drive enable
    input  wire logic       pulldown_in, // debug pin pull-down on
    input  wire logic [7:0] ext_val_in,  // board drive value
    input  wire logic [7:0] ext_en_in,   // board drive enable
    output logic      [7:0] pin_lvl_out  // resolved pin levels
);
    import ppd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // floating pins wander so a stale level never passes for a real one
    logic [7:0] idle_q = 8'h55;

    always_ff @(posedge clk_in) begin
        idle_q <= ~idle_q;
    end

    // level resolution per pin
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe_in[i]) begin
                pin_lvl_out[i] = pin_out_in[i];
            end else if (ext_en_in[i]) begin
                pin_lvl_out[i] = ext_val_in[i];
            end else if (i == PPD_NMI_BIT) begin
                pin_lvl_out[i] = 1'b1;  // pulled up
            end else if (i == PPD_INT2_BIT && pulldown_in) begin
                pin_lvl_out[i] = 1'b0;
            end else begin
                pin_lvl_out[i] = idle_q[i];
            end
        end
    end
endmodule // ppd_pin_model

// ### tb/ppd_port_tb.sv
/*
 * self-checking bench for ppd_port: debug pin, mode-switch edges,
 * bit operations and pin drive against a small reference model.
 * assumes ppd_pin_model stands in for the board at the pins.
 */
`timescale 1ns/1ps

module ppd_port_tb;
    import ppd_pkg::*;

    logic       CLK_IN, SYS_RST_IN, INT_RST_IN, WR_IN, RD_IN;
    logic       NMI_OUT, IRQ_OUT, PULLDOWN_OUT, DEBUG_MODE_OUT;
    logic [3:0] ADDR_IN;
    logic [7:0] WDATA_IN, RDATA_OUT, PIN_IN, PIN_OUT, PIN_OE_OUT;
    logic [7:0] ALT_OUT_IN, ALT_OE_IN, ALT_SIG_OUT, ext_val, ext_en;
    logic [7:0] m_dir, m_latch, m_ods, view;
    int         err_total, n_compared, op, idx;

    ppd_port uut (.CLK_IN, .SYS_RST_IN, .INT_RST_IN, .ADDR_IN, .WDATA_IN, .WR_IN,
        .RD_IN, .RDATA_OUT, .PIN_IN, .PIN_OUT, .PIN_OE_OUT, .ALT_OUT_IN, .ALT_OE_IN,
        .ALT_SIG_OUT, .NMI_OUT, .IRQ_OUT, .PULLDOWN_OUT, .DEBUG_MODE_OUT);
    ppd_pin_model board (.clk_in(CLK_IN), .pin_out_in(PIN_OUT), .pin_oe_in(PIN_OE_OUT),
        .pulldown_in(PULLDOWN_OUT), .ext_val_in(ext_val), .ext_en_in(ext_en),
        .pin_lvl_out(PIN_IN));

    ////////////////////////////////////////////////////////////////////////
    always #10 CLK_IN = ~CLK_IN;

    task automatic complete_run;
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge CLK_IN);
        #1;
    endtask

    // one-cycle strobes, launched just after an edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLK_IN);
        ADDR_IN <= a;
        WDATA_IN <= d;
        WR_IN <= 1'b1;
        @(posedge CLK_IN);
        WR_IN <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge CLK_IN);
        ADDR_IN <= a;
        RD_IN <= 1'b1;
        @(posedge CLK_IN);
        RD_IN <= 1'b0;
        #1 chk(RDATA_OUT, exp);
    endtask

    // pulses are one cycle wide, so count them over a fixed window
    task automatic nmi_count(input logic [7:0] exp);
        logic [7:0] n;
        n = 8'h00;
        repeat (6) begin
            @(posedge CLK_IN);
            #1 n = n + {7'h0, NMI_OUT};
        end
        chk(n, exp);
    endtask

    task automatic int_reset;
        @(posedge CLK_IN) INT_RST_IN <= 1'b1;
        @(posedge CLK_IN) INT_RST_IN <= 1'b0;
        tick(2);
    endtask

    // cut a hang short
    initial begin
        repeat (5000) @(posedge CLK_IN);
        err_total++;
        complete_run;
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        CLK_IN = 1'b0;
        SYS_RST_IN = 1'b1;
        {INT_RST_IN, WR_IN, RD_IN, ADDR_IN, WDATA_IN} = '0;
        {ALT_OUT_IN, ALT_OE_IN, ext_val, ext_en} = '0;
        err_total = 0;
        n_compared = 0;
        void'($urandom(32'h7ffd3f51));
        repeat (12) @(posedge CLK_IN);
        SYS_RST_IN <= 1'b0;
        tick(1);
        // pin reset: debug function, pull-down on
        chk({7'h0, PULLDOWN_OUT}, 8'h01);
        rd(PPD_OFF_DBG, 8'h01);
        rd(PPD_OFF_DIR, PPD_RST_DIR);
        chk({7'h0, DEBUG_MODE_OUT}, 8'h00);
        // board raises the debug pin on purpose
        ext_en <= 8'h20;
        ext_val <= 8'h20;
        tick(5);
        chk({7'h0, DEBUG_MODE_OUT}, 8'h01);
        int_reset;
        chk({7'h0, DEBUG_MODE_OUT}, 8'h01);
        rd(PPD_OFF_DBG, 8'h01);
        ext_val <= 8'h00;
        wr(PPD_OFF_DBG, 8'h00);
        tick(2);
        chk({6'h0, PULLDOWN_OUT, DEBUG_MODE_OUT}, 8'h00);
        wr(PPD_OFF_DIR, 8'h00);
        int_reset;
        rd(PPD_OFF_DIR, PPD_RST_DIR);
        rd(PPD_OFF_DBG, 8'h00);
        chk({7'h0, PULLDOWN_OUT}, 8'h00);
        // edge chosen before the switch, the unsafe order on purpose
        ext_en <= 8'h00;
        wr(PPD_OFF_EDGE, 8'h01);
        wr(PPD_OFF_MASK, 8'h01);
        wr(PPD_OFF_FSEL, 8'h04);
        nmi_count(8'h01);
        chk({7'h0, ALT_SIG_OUT[2]}, 8'h01);
        chk({7'h0, IRQ_OUT}, 8'h01);
        rd(PPD_OFF_STAT, 8'h01);
        wr(PPD_OFF_STAT, 8'h01);
        tick(2);
        chk({7'h0, IRQ_OUT}, 8'h00);
        wr(PPD_OFF_EDGE, 8'h02);
        nmi_count(8'h00);
        wr(PPD_OFF_FSEL, 8'h00);
        nmi_count(8'h01);
        chk({7'h0, ALT_SIG_OUT[2]}, 8'h00);
        // switch to the function first, pick the edge after
        wr(PPD_OFF_EDGE, 8'h00);
        wr(PPD_OFF_FSEL, 8'h04);
        wr(PPD_OFF_EDGE, 8'h01);
        nmi_count(8'h00);
        // no edge before leaving function mode
        wr(PPD_OFF_EDGE, 8'h00);
        wr(PPD_OFF_FSEL, 8'h00);
        nmi_count(8'h00);
        // alternate mode hands the pins to the peripheral
        @(posedge CLK_IN);
        ALT_OUT_IN <= 8'($urandom);
        ALT_OE_IN <= 8'($urandom);
        wr(PPD_OFF_FSEL, 8'hFF);
        tick(1);
        chk(PIN_OUT, ALT_OUT_IN);
        chk(PIN_OE_OUT, ALT_OE_IN);
        wr(PPD_OFF_FSEL, 8'h00);
        // random port traffic against the reference model
        m_latch = PPD_RST_ZERO;
        for (int k = 0; k < 24; k++) begin
            m_dir = 8'($urandom);
            m_ods = 8'($urandom);
            ext_en <= 8'hFF;
            ext_val <= 8'($urandom);
            wr(PPD_OFF_DIR, m_dir);
            wr(PPD_OFF_ODS, m_ods);
            if (k % 3 == 0) begin
                m_latch = 8'($urandom);
                wr(PPD_OFF_DATA, m_latch);
            end
            tick(4);
            rd(PPD_OFF_DATA, (m_dir & ext_val) | (~m_dir & m_latch));
            chk(PIN_OE_OUT, ~m_dir & ~(m_ods & m_latch));
            idx = $urandom_range(7, 0);
            op = $urandom_range(3, 1);
            view = (m_dir & ext_val) | (~m_dir & m_latch);
            view[idx] = (op == 1) ? 1'b1 : (op == 2) ? 1'b0 : ~view[idx];
            m_latch = view;
            wr(PPD_OFF_BITOP, {2'h0, 2'(op), 1'b0, 3'(idx)});
            tick(2);
            chk(PIN_OUT, m_latch & ~(m_ods & ~m_dir));
        end
        rd(PPD_OFF_BITOP, 8'h00);
        rd(4'hF, 8'h00);
        // int2 rising edge once the debug function is gone
        ALT_OE_IN <= 8'h00;
        ext_val <= 8'h00;
        wr(PPD_OFF_STAT, 8'h03);
        wr(PPD_OFF_FSEL, 8'h20);
        wr(PPD_OFF_EDGE, 8'h04);
        wr(PPD_OFF_MASK, 8'h02);
        ext_val <= 8'h20;
        tick(5);
        rd(PPD_OFF_STAT, 8'h02);
        chk({7'h0, IRQ_OUT}, 8'h01);
        // second pin reset restores the debug function
        ext_val <= 8'h00;
        SYS_RST_IN <= 1'b1;
        tick(2);
        SYS_RST_IN <= 1'b0;
        tick(1);
        chk({7'h0, PULLDOWN_OUT}, 8'h01);
        rd(PPD_OFF_DBG, 8'h01);
        complete_run;
    end
endmodule // ppd_port_tb
